/* File: hdl/nco_device.sv */
/*
  Device end: eight-preset complex oscillator, real-by-complex mixer,
  byte-wide register port and link bring-up. Assumes one sample per mclk
  and that the far end programs divider and words as documented.
*/
`timescale 1ns/1ns
`default_nettype none

module nco_device
  import nco_pkg::*;
(
  nco_if.dev_mp            link,
  input  wire logic [11:0] adc_sample,
  output logic [2:0]       active_preset,
  output logic             pd_active
);
  logic        src_sel_r;
  preset_select_config_t    sel_field_r;
  logic [15:0] rdiv_r;
  logic        rat_en_r;
  logic        pd_r;
  logic        link_up_r;
  logic        dirty_r;
  logic [3:0]  flush_cnt_r;
  logic [7:0]  rdata_r;
  logic        rvalid_r;
  logic [31:0] freq_all  [8];
  logic [15:0] phase_all [8];
  logic [31:0] phs_all   [8];
  preset_select_config_t    sel;
  logic        word_wr;

  // Quarter-wave sine, 17 points, amplitude 2047
  localparam logic [11:0] SIN_T [17] = '{
    12'h000, 12'h0C9, 12'h18F, 12'h252, 12'h30F, 12'h3C5, 12'h471, 12'h513,
    12'h5A7, 12'h62E, 12'h6A6, 12'h70D, 12'h763, 12'h7A7, 12'h7D7, 12'h7F5, 12'h7FF};

  assign sel = src_sel_r ? sel_field_r : link.preset_select_pins;
  assign active_preset = sel;
  assign pd_active = pd_r;
  assign word_wr = link.reg_wr && link.reg_addr >= `NCO_FREQ_BASE
                   && link.reg_addr <= `NCO_CTRL;

  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      src_sel_r   <= 1'b0;
      sel_field_r <= 3'h0;
      rdiv_r      <= `RATIONAL_DIVIDER_RESET;
      rat_en_r    <= 1'b0;
      pd_r        <= 1'b1;
    end else if (link.reg_wr) begin
      case (link.reg_addr)
        `NCO_SRC_CFG: src_sel_r   <= link.reg_wdata[`NCO_SRC_BIT];
        `PRESET_SELECT_CONFIG_CFG: sel_field_r <= link.reg_wdata[`PRESET_SELECT_CONFIG_LSB +: 3];
        `RATIONAL_DIVIDER_LO: rdiv_r[7:0] <= link.reg_wdata;
        `RATIONAL_DIVIDER_HI: rdiv_r[15:8] <= link.reg_wdata;
        `NCO_CTRL: begin
          rat_en_r <= link.reg_wdata[`NCO_CTRL_RAT_BIT];
          pd_r     <= link.reg_wdata[`NCO_CTRL_PD_BIT];
        end
        default: ;
      endcase
    end
  end

  // Per-preset word storage and free-running accumulator
  for (genvar g = 0; g < `NCO_PRESETS; g++) begin : g_preset
    logic [31:0]        freq_r;
    logic [15:0]        phase_r;
    logic [31:0]        acc_r;
    logic signed [16:0] frac_r;
    logic signed [16:0] frac_nxt;
    logic [31:0]        step;
    logic [47:0]        prod;
    logic [24:0]        low;
    logic signed [16:0] dlt;
    logic signed [17:0] fsum;

    always_ff @(posedge link.mclk or posedge link.rst) begin
      if (link.rst) begin
        freq_r  <= 32'h0000_0000;
        phase_r <= 16'h0000;
      end else if (link.reg_wr) begin
        for (int b = 0; b < 4; b++) begin
          if (link.reg_addr == 12'(`NCO_FREQ_BASE + 4 * g + b))
            freq_r[8 * b +: 8] <= link.reg_wdata;
        end
        for (int b = 0; b < 2; b++) begin
          if (link.reg_addr == 12'(`NCO_PHASE_BASE + 2 * g + b))
            phase_r[8 * b +: 8] <= link.reg_wdata;
        end
      end
    end

    // Word is rounded; the residue of word*divider against a multiple of
    // 2^25 is the exact per-sample error, carried in units of 1/divider.
    assign prod = freq_r * rdiv_r;
    assign low  = prod[24:0];
    assign dlt  = low[24] ? $signed(17'(26'h2000000 - {1'b0, low}))
                          : -$signed(17'(low));
    assign fsum = 18'(frac_r) + 18'(dlt);

    always_comb begin
      frac_nxt = 17'sh0;
      step     = freq_r;
      if (rat_en_r && rdiv_r != 16'h0000) begin
        if (fsum >= $signed({2'b00, rdiv_r})) begin
          frac_nxt = $signed(17'(fsum - $signed({2'b00, rdiv_r})));
          step     = freq_r + 32'h0000_0001;
        end else if (fsum < 18'sh0) begin
          frac_nxt = $signed(17'(fsum + $signed({2'b00, rdiv_r})));
          step     = freq_r - 32'h0000_0001;
        end else begin
          frac_nxt = 17'(fsum);
        end
      end
    end

    // Runs regardless of selection or power-down, so a switch is instant
    always_ff @(posedge link.mclk or posedge link.rst) begin
      if (link.rst) begin
        acc_r  <= 32'h0000_0000;
        frac_r <= 17'sh0;
      end else begin
        acc_r  <= acc_r + step;
        frac_r <= frac_nxt;
      end
    end

    assign freq_all[g]  = freq_r;
    assign phase_all[g] = phase_r;
    assign phs_all[g]   = acc_r + {phase_r, 16'h0000};
  end

  // Mixer pipeline: phase select, sine lookup, multiply
  logic [5:0]         ph_r;
  logic signed [11:0] x1_r;
  logic signed [11:0] x2_r;
  logic signed [12:0] cos_r;
  logic signed [12:0] sin_r;
  logic [14:0]        i_r;
  logic [14:0]        q_r;
  logic               vld_r;
  logic signed [24:0] i_prod;
  logic signed [24:0] q_prod;

  function automatic logic signed [12:0] nco_sine(input logic [5:0] p);
    logic [11:0] mag;
    mag = p[4] ? SIN_T[5'(16) - {1'b0, p[3:0]}] : SIN_T[{1'b0, p[3:0]}];
    if (p[4] && p[3:0] == 4'h0)
      mag = SIN_T[16];
    return p[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      ph_r  <= 6'h00;
      x1_r  <= 12'sh000;
      x2_r  <= 12'sh000;
      cos_r <= 13'sh0000;
      sin_r <= 13'sh0000;
    end else begin
      ph_r  <= phs_all[sel][31:26];
      x1_r  <= $signed(adc_sample);
      x2_r  <= x1_r;
      cos_r <= nco_sine(ph_r + 6'h10);
      sin_r <= nco_sine(ph_r);
    end
  end

  // e^(-jwn) so the chosen carrier moves down to 0 Hz
  assign i_prod = x2_r * cos_r;
  assign q_prod = -(x2_r * sin_r);

  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      i_r   <= 15'h0000;
      q_r   <= 15'h0000;
      vld_r <= 1'b0;
    end else begin
      i_r   <= pd_r ? 15'h0000 : i_prod[22:8];
      q_r   <= pd_r ? 15'h0000 : q_prod[22:8];
      vld_r <= link_up_r && !pd_r;
    end
  end

  // Link bring-up: flush the pipeline before data counts as good
  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      link_up_r   <= 1'b0;
      flush_cnt_r <= 4'h0;
    end else if (pd_r) begin
      link_up_r   <= 1'b0;
      flush_cnt_r <= 4'h0;
    end else if (link.link_init) begin
      link_up_r   <= 1'b0;
      flush_cnt_r <= `NCO_FLUSH_CYCLES;
    end else if (flush_cnt_r != 4'h0) begin
      flush_cnt_r <= flush_cnt_r - 4'h1;
      link_up_r   <= flush_cnt_r == 4'h1;
    end
  end

  // Phase no longer deterministic; set beats the clear by link_init
  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst)
      dirty_r <= 1'b0;
    else if (word_wr && link_up_r)
      dirty_r <= 1'b1;
    else if (link.link_init)
      dirty_r <= 1'b0;
  end

  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= link.reg_rd;
      if (link.reg_rd) begin
        rdata_r <= 8'h00;
        case (link.reg_addr)
          `NCO_SRC_CFG: rdata_r <= {7'h00, src_sel_r};
          `PRESET_SELECT_CONFIG_CFG: rdata_r <= {5'h00, sel_field_r};
          `RATIONAL_DIVIDER_LO: rdata_r <= rdiv_r[7:0];
          `RATIONAL_DIVIDER_HI: rdata_r <= rdiv_r[15:8];
          `NCO_CTRL:    rdata_r <= {6'h00, pd_r, rat_en_r};
          `NCO_STATUS:  rdata_r <= {1'b0, sel, 2'b00, dirty_r, link_up_r};
          default: begin
            for (int k = 0; k < `NCO_PRESETS; k++) begin
              for (int b = 0; b < 4; b++) begin
                if (link.reg_addr == 12'(`NCO_FREQ_BASE + 4 * k + b))
                  rdata_r <= freq_all[k][8 * b +: 8];
              end
              for (int b = 0; b < 2; b++) begin
                if (link.reg_addr == 12'(`NCO_PHASE_BASE + 2 * k + b))
                  rdata_r <= phase_all[k][8 * b +: 8];
              end
            end
          end
        endcase
      end
    end
  end

  assign link.reg_rdata  = rdata_r;
  assign link.reg_rvalid = rvalid_r;
  assign link.link_up    = link_up_r;
  assign link.serial_oe  = !pd_r;
  assign link.out_valid  = vld_r;
  assign link.i_data     = i_r;
  assign link.q_data     = q_r;
endmodule

`default_nettype wire

/* File: hdl/nco_map.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  multi-preset oscillator and mixer. Assumes it is included by bare name
  from the package, the property checker and the self-checking bench.
*/
// Summary of operation
// - Eight presets, each with its own accumulator.
// - All accumulators always run, switching is immediate.
// - Bit 0 at 0x20C picks selection source.
// - Source 0: three input pins pick preset.
// - Source 1: field bits 2:0 at 0x20D pick.
// - Separate frequency and phase word per preset.
// - Basic: 32-bit word, f = word*2^-32*fs.
// - Real sample times complex exponential, carrier to 0 Hz.
// - Rational divider removes frequency truncation error.
// - Divider equals fs/step/128, an integer.
// - Word equals round(2^25*N/divider).
// - Keep divider at or below 8192.
// - Phase word left-justified, added to accumulator.
// - Phase word angle is word*2^-16*2*pi.
// - Word change while linked: reinitialise link.
// - Power-down disables serial output drivers.
// - After power-down: flush, re-establish link.
`ifndef NCO_MAP_SVH
`define NCO_MAP_SVH

`define NCO_ADDR_W        12
`define NCO_PRESETS       8
`define NCO_SRC_CFG       12'h20C
`define NCO_SRC_BIT       0
`define PRESET_SELECT_CONFIG_CFG       12'h20D
`define PRESET_SELECT_CONFIG_LSB       0
`define NCO_FREQ_BASE     12'h210
`define NCO_PHASE_BASE    12'h230
`define RATIONAL_DIVIDER_LO       12'h240
`define RATIONAL_DIVIDER_HI       12'h241
`define NCO_CTRL          12'h242
`define NCO_CTRL_RAT_BIT  0
`define NCO_CTRL_PD_BIT   1
`define NCO_STATUS        12'h243
`define NCO_ST_UP_BIT     0
`define NCO_ST_DIRTY_BIT  1
`define NCO_ST_SEL_LSB    4
`define NCO_CTRL_RESET    8'h02
`define RATIONAL_DIVIDER_RESET    16'h0000
`define RATIONAL_DIVIDER_MAX      16'h2000
`define NCO_FLUSH_CYCLES  4'h8

`endif

/* File: hdl/nco_pkg.sv */
/*
  Types shared by both ends of the oscillator link.
  Assumes the constant header sits on the include path.
*/
`include "nco_map.svh"

package nco_pkg;
  typedef logic [2:0]  preset_select_config_t;
  typedef logic [11:0] nco_addr_t;
  typedef enum logic [1:0] {
    NCO_IDLE,
    NCO_READ_WAIT,
    NCO_INIT,
    NCO_WAIT_UP
  } nco_host_state_t;
endpackage

/* File: hdl/nco_if.sv */
/*
  Connection between the oscillator/mixer device and the downstream logic.
  Assumes one clock (the sample clock) and one active-high asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

interface nco_if (
  input wire logic mclk,
  input wire logic rst
);
  logic [2:0]  preset_select_pins;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        link_init;
  logic        link_up;
  logic        serial_oe;
  logic        out_valid;
  logic [14:0] i_data;
  logic [14:0] q_data;

  modport dev_mp (
    input  mclk, rst, preset_select_pins, reg_wr, reg_rd, reg_addr, reg_wdata, link_init,
    output reg_rdata, reg_rvalid, link_up, serial_oe, out_valid, i_data, q_data
  );
  modport host_mp (
    input  mclk, rst, reg_rdata, reg_rvalid, link_up, serial_oe, out_valid, i_data, q_data,
    output preset_select_pins, reg_wr, reg_rd, reg_addr, reg_wdata, link_init
  );
endinterface

`default_nettype wire

/* File: hdl/nco_host.sv */
/*
  Downstream-logic end: forwards register commands, drives the preset pins,
  re-establishes the link after tuning or power-up and passes on only
  trusted samples. Assumes the user computes divider and words itself.
*/
`timescale 1ns/1ns
`default_nettype none

module nco_host
  import nco_pkg::*;
(
  nco_if.host_mp           link,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [11:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  input  wire logic [2:0]  preset_pins_in,
  output logic             user_valid,
  output logic [14:0]      user_i,
  output logic [14:0]      user_q,
  output logic             rdiv_warn
);
  nco_host_state_t state_r;
  logic            wr_r;
  logic            rd_r;
  logic [11:0]     addr_r;
  logic [7:0]      wdata_r;
  logic            init_r;
  logic [2:0]      pins_r;
  logic            rsp_valid_r;
  logic [7:0]      rsp_rdata_r;
  logic            uvalid_r;
  logic [14:0]     ui_r;
  logic [14:0]     uq_r;
  logic [15:0]     rdiv_shadow_r;
  logic            needs_init;

  assign cmd_ready = state_r == NCO_IDLE;
  // Tuning words, divider, mode or leaving power-down all need a new link
  assign needs_init = (cmd_addr >= `NCO_FREQ_BASE && cmd_addr <= `RATIONAL_DIVIDER_HI)
                      || (cmd_addr == `NCO_CTRL && !cmd_wdata[`NCO_CTRL_PD_BIT]);

  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      state_r <= NCO_IDLE;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      addr_r  <= 12'h000;
      wdata_r <= 8'h00;
      init_r  <= 1'b0;
    end else begin
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      init_r <= 1'b0;
      case (state_r)
        NCO_IDLE: begin
          if (cmd_valid) begin
            addr_r  <= cmd_addr;
            wdata_r <= cmd_wdata;
            wr_r    <= cmd_write;
            rd_r    <= !cmd_write;
            if (!cmd_write)
              state_r <= NCO_READ_WAIT;
            else if (needs_init)
              state_r <= NCO_INIT;
          end
        end
        NCO_READ_WAIT: begin
          if (link.reg_rvalid)
            state_r <= NCO_IDLE;
        end
        NCO_INIT: begin
          init_r  <= 1'b1;
          state_r <= NCO_WAIT_UP;
        end
        NCO_WAIT_UP: begin
          // First cycle here sees link_up from before the restart
          if (!init_r && (link.link_up || !link.serial_oe))
            state_r <= NCO_IDLE;
        end
        default: state_r <= NCO_IDLE;
      endcase
    end
  end

  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 8'h00;
    end else begin
      rsp_valid_r <= state_r == NCO_READ_WAIT && link.reg_rvalid;
      if (state_r == NCO_READ_WAIT && link.reg_rvalid)
        rsp_rdata_r <= link.reg_rdata;
    end
  end

  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst)
      pins_r <= 3'h0;
    else
      pins_r <= preset_pins_in;
  end

  // Divider is the user's to compute; only the SFDR limit is flagged
  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst)
      rdiv_shadow_r <= `RATIONAL_DIVIDER_RESET;
    else if (cmd_valid && cmd_ready && cmd_write && cmd_addr == `RATIONAL_DIVIDER_LO)
      rdiv_shadow_r[7:0] <= cmd_wdata;
    else if (cmd_valid && cmd_ready && cmd_write && cmd_addr == `RATIONAL_DIVIDER_HI)
      rdiv_shadow_r[15:8] <= cmd_wdata;
  end

  // Samples count only on an established link with no pending restart
  always_ff @(posedge link.mclk or posedge link.rst) begin
    if (link.rst) begin
      uvalid_r <= 1'b0;
      ui_r     <= 15'h0000;
      uq_r     <= 15'h0000;
    end else begin
      uvalid_r <= link.out_valid && link.link_up && state_r != NCO_INIT
                  && state_r != NCO_WAIT_UP;
      ui_r     <= link.i_data;
      uq_r     <= link.q_data;
    end
  end

  assign link.preset_select_pins = pins_r;
  assign link.reg_wr    = wr_r;
  assign link.reg_rd    = rd_r;
  assign link.reg_addr  = addr_r;
  assign link.reg_wdata = wdata_r;
  assign link.link_init = init_r;
  assign rsp_valid  = rsp_valid_r;
  assign rsp_rdata  = rsp_rdata_r;
  assign user_valid = uvalid_r;
  assign user_i     = ui_r;
  assign user_q     = uq_r;
  assign rdiv_warn  = rdiv_shadow_r > `RATIONAL_DIVIDER_MAX;
endmodule

`default_nettype wire

/* File: testbench/nco_link_properties.sv */
/*
  Concurrent checks on the signals between the oscillator device and the
  downstream logic. Assumes one clock, an active-high reset, and that it is
  instantiated once beside the interface that joins the two ends.
*/
`timescale 1ns/1ns
`default_nettype none
`include "nco_map.svh"

module nco_link_properties (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [2:0]  preset_select_pins,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        link_init,
  input wire logic        link_up,
  input wire logic        serial_oe,
  input wire logic        out_valid,
  input wire logic [14:0] i_data,
  input wire logic [14:0] q_data
);
  logic [2:0] sel_r;
  logic       src_r;
  logic [2:0] pick;

  // Shadows of what was written, so readback needs no access to the device
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_r <= 3'h0;
    end else if (reg_wr && reg_addr == `PRESET_SELECT_CONFIG_CFG) begin
      sel_r <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_r <= 1'b0;
    end else if (reg_wr && reg_addr == `NCO_SRC_CFG) begin
      src_r <= reg_wdata[`NCO_SRC_BIT];
    end
  end

  assign pick = src_r ? sel_r : preset_select_pins;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence rd_of(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence powered_init;
    link_init && serial_oe;
  endsequence

  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  src_read_a: assert property (rd_of(`NCO_SRC_CFG) |=> reg_rdata[0] == src_r)
    else $error("source bit readback wrong");
  sel_read_a: assert property (rd_of(`PRESET_SELECT_CONFIG_CFG) |=> reg_rdata[2:0] == sel_r)
    else $error("select field readback wrong");
  pins_pick_a: assert property (rd_of(`NCO_STATUS) |=> reg_rdata[6:4] == $past(pick))
    else $error("active preset not from chosen source");
  pd_valid_a: assert property (!serial_oe |=> !out_valid)
    else $error("output valid while drivers off");
  pd_zero_a: assert property (!serial_oe [*3] |-> i_data == 15'h0 && q_data == 15'h0)
    else $error("samples not zero while powered down");
  up_power_a: assert property (!serial_oe [*2] |-> !link_up)
    else $error("link up while powered down");
  flush_hold_a: assert property (powered_init |=> !link_up [*6])
    else $error("link up before flush");
  link_back_a: assert property (powered_init |-> ##[6:12] (link_up || !serial_oe))
    else $error("link not re-established in time");
  init_quiet_a: assert property (powered_init |=> !(reg_wr || reg_rd) [*8])
    else $error("register access during link restart");
endmodule

`default_nettype wire

/* File: testbench/multi_preset_nco_mixer_tb_top.sv */
/*
  Self-checking bench: both ends joined by the interface, host command port
  and device sample input driven here. Assumes the checker sits beside it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "nco_map.svh"

module multi_preset_nco_mixer_tb_top;
  logic        mclk, rst, cmd_valid, cmd_write, cmd_ready, rsp_valid, user_valid;
  logic        rdiv_warn, pd_active;
  logic [11:0] cmd_addr, adc_sample, x;
  logic [7:0]  cmd_wdata, rsp_rdata;
  logic [2:0]  preset_pins_in, active_preset;
  logic [14:0] user_i, user_q;
  logic [14:0] iv[5], qv[5];
  logic [15:0] e;
  logic [15:0] exp_q[$];
  int          failures, checks, seed;
  int          cosv[4] = '{2047, 0, -2047, 0};
  int          sinv[4] = '{0, 2047, 0, -2047};

  nco_if nco_if_inst (.mclk(mclk), .rst(rst));
  nco_device nco_device_inst (.link(nco_if_inst), .adc_sample(adc_sample),
    .active_preset(active_preset), .pd_active(pd_active));
  nco_host nco_host_inst (.link(nco_if_inst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .preset_pins_in(preset_pins_in), .user_valid(user_valid),
    .user_i(user_i), .user_q(user_q), .rdiv_warn(rdiv_warn));
  nco_link_properties nco_link_properties_inst (.mclk(mclk), .rst(rst),
    .preset_select_pins(nco_if_inst.preset_select_pins), .reg_wr(nco_if_inst.reg_wr),
    .reg_rd(nco_if_inst.reg_rd), .reg_addr(nco_if_inst.reg_addr),
    .reg_wdata(nco_if_inst.reg_wdata), .reg_rdata(nco_if_inst.reg_rdata),
    .reg_rvalid(nco_if_inst.reg_rvalid), .link_init(nco_if_inst.link_init),
    .link_up(nco_if_inst.link_up), .serial_oe(nco_if_inst.serial_oe),
    .out_valid(nco_if_inst.out_valid), .i_data(nco_if_inst.i_data),
    .q_data(nco_if_inst.q_data));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] expv);
    checks++;
    if (seen !== expv) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Request held until the edge that finds the host ready
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk); #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(posedge mclk); #1;
      n++;
    end
    if (n >= 300) failures++;
    @(posedge mclk); #1;
    cmd_valid = 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
    exp_q.push_back({m, d});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wait_up;
    int n;
    n = 0;
    // Give a restart time to pull user_valid low first
    repeat (2) @(posedge mclk);
    #1;
    while (user_valid !== 1'b1 && n < 300) begin
      @(posedge mclk); #1;
      n++;
    end
    if (n >= 300) failures++;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // Floor of the 25-bit product, as the mixer keeps its upper bits
  function automatic logic [14:0] mix(input logic [11:0] s, input int c);
    int p;
    p = $signed(s) * c;
    return 15'(p >>> 8);
  endfunction

  always @(posedge mclk) begin
    if (!rst && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("extra_rsp", 16'h1, 16'h0);
      end else begin
        e = exp_q.pop_front();
        chk("rsp", {8'h0, rsp_rdata & e[15:8]}, {8'h0, e[7:0] & e[15:8]});
      end
    end
  end

  initial begin
    #400000;
    failures++;
    wrap_up();
  end

  initial begin
    seed = 32'h9a274cb2;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 12'h000;
    cmd_wdata = 8'h00;
    preset_pins_in = 3'h0;
    adc_sample = 12'h300;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("oe_reset", {15'h0, nco_if_inst.serial_oe}, 16'h0);
    chk("pd_reset", {15'h0, pd_active}, 16'h1);
    wr(`NCO_SRC_CFG, 8'h01);
    rd(`NCO_SRC_CFG, 8'h01, 8'h01);
    for (int b = 0; b < 4; b++) wr(`NCO_FREQ_BASE + 12'h4 + 12'(b), b == 3 ? 8'h40 : 8'h00);
    wr(`NCO_CTRL, 8'h00);
    wait_up();
    chk("up", {15'h0, user_valid}, 16'h1);
    for (int s = 0; s < 8; s++) begin
      wr(`PRESET_SELECT_CONFIG_CFG, 8'(s));
      rd(`PRESET_SELECT_CONFIG_CFG, 8'(s), 8'h07);
      rd(`NCO_STATUS, {1'b0, 3'(s), 4'h1}, 8'h71);
    end
    wr(`PRESET_SELECT_CONFIG_CFG, 8'h00);
    for (int k = 0; k < 4; k++) begin
      x = 12'($random(seed));
      adc_sample = x;
      wr(`NCO_PHASE_BASE + 12'h1, 8'(k * 64));
      wait_up();
      chk("i_phase", {1'b0, user_i}, {1'b0, mix(x, cosv[k])});
      chk("q_phase", {1'b0, user_q}, {1'b0, mix(x, -sinv[k])});
    end
    // Quarter-turn step: each sample rotates the exponential by 90 degrees.
    // Second pass in rational mode: word 2^30 is exact for divider 3, N 96.
    adc_sample = 12'h300;
    for (int m = 0; m < 2; m++) begin
      if (m == 0) begin
        wr(`PRESET_SELECT_CONFIG_CFG, 8'h01);
      end else begin
        wr(`RATIONAL_DIVIDER_LO, 8'h03);
        wr(`NCO_CTRL, 8'h01);
        rd(`NCO_CTRL, 8'h01, 8'h03);
      end
      wait_up();
      for (int j = 0; j < 5; j++) begin
        iv[j] = user_i;
        qv[j] = user_q;
        @(posedge mclk); #1;
      end
      for (int j = 0; j < 4; j++) begin
        chk("rotate", {1'b0, iv[j + 1]}, {1'b0, qv[j]});
        chk("quadrant", {15'h0, (iv[j] === 15'h0) != (qv[j] === 15'h0)}, 16'h1);
      end
      chk("period", {1'b0, iv[4]}, {1'b0, iv[0]});
    end
    wr(`RATIONAL_DIVIDER_LO, 8'h01);
    wr(`RATIONAL_DIVIDER_HI, 8'h20);
    repeat (2) @(posedge mclk);
    #1;
    chk("warn_hi", {15'h0, rdiv_warn}, 16'h1);
    wr(`RATIONAL_DIVIDER_LO, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    chk("warn_lo", {15'h0, rdiv_warn}, 16'h0);
    wr(`NCO_SRC_CFG, 8'h00);
    for (int k = 0; k < 4; k++) begin
      preset_pins_in = 3'($random(seed));
      repeat (4) @(posedge mclk);
      #1;
      chk("pins", {13'h0, active_preset}, {13'h0, preset_pins_in});
      rd(`NCO_STATUS, {1'b0, preset_pins_in, 4'h0}, 8'h70);
    end
    rd(12'h000, 8'h00, 8'hFF);
    wr(`NCO_CTRL, 8'h02);
    repeat (3) @(posedge mclk);
    #1;
    chk("oe_pd", {15'h0, nco_if_inst.serial_oe}, 16'h0);
    chk("valid_pd", {15'h0, user_valid}, 16'h0);
    // Control write landed while the link was up: phase now untrusted
    rd(`NCO_STATUS, 8'h02, 8'h03);
    wr(`NCO_CTRL, 8'h00);
    wait_up();
    chk("up_again", {15'h0, user_valid}, 16'h1);
    rd(`NCO_STATUS, 8'h01, 8'h03);
    repeat (8) @(posedge mclk);
    chk("pending", 16'(exp_q.size()), 16'h0);
    wrap_up();
  end
endmodule

`default_nettype wire
